/* verilog/status_event_rx_readout.sv */
// Purpose: Status word two, two clear-on-read event registers with buffered read,
//          received word bytes, channel lock pin and interrupt line
// Assumes: Read requests and event pulses come from logic on clk
// Notes:   Unmapped read addresses return zero
`timescale 1ns/1ps
`default_nettype none

module status_event_rx_readout
    import evt_status_pkg::*;
(
    input  wire logic                          clk,
    input  wire logic                          rst_b,
    input  wire logic                          clk_en,
    input  wire rd_req_t                       rd_req,
    output var  logic [7:0]                    rd_data,
    output var  logic                          interrupt_request_n,
    input  wire logic [6:0]                    evt_a_mask,
    input  wire logic [7:0]                    evt_b_mask,
    input  wire logic [5:0]                    evt_a_pulse,
    input  wire logic                          tone_eval,
    input  wire logic                          tone_mismatch,
    input  wire rx_word_t                      rx_word_in,
    input  wire logic [RX_BITS*VOTE_W-1:0]     vote_ones,
    input  wire logic [RX_BITS*VOTE_W-1:0]     vote_zeros,
    output var  logic                          erasure_over_two,
    input  wire logic                          voice_msg_rx,
    input  wire logic                          ctrl_sync,
    input  wire logic                          idle_save,
    input  wire logic                          channel_type_select,
    input  wire logic                          voice_dotting,
    input  wire logic                          voice_frame_sync,
    input  wire logic                          narrowband_error_update,
    input  wire logic                          port_input_three,
    input  wire logic                          freq_corr_done,
    output var  logic                          channel_lock
);

    state_t            st;
    state_t            next_st;
    logic [RX_BITS-1:0] bit_erased;
    logic [6:0]        ev_a;
    logic [7:0]        ev_b;
    logic              tone_event;
    logic              data_change;
    logic              pending;
    logic [7:0]        status_two;
    logic [5:0]        erase_count;
    logic              rd_evt_a;

    // Per-bit erasure: equal nonzero tallies of ones and zeros over valid repeats
    generate
        for (genvar i = 0; i < RX_BITS; i++)
        begin : g_erase
            assign bit_erased[i] = (vote_ones[i*VOTE_W +: VOTE_W] != '0) &&
                (vote_ones[i*VOTE_W +: VOTE_W] == vote_zeros[i*VOTE_W +: VOTE_W]); // R19
        end
    endgenerate

    // Event sources gathered into register layout
    always_comb
    begin
        tone_event  = tone_eval && (!st.tone_seen || (tone_mismatch != st.tone_last)); // R3
        data_change = rx_word_in.valid &&
                      (!st.word_seen || (rx_word_in.data != st.prev_word)); // R12
        ev_a        = {tone_event, evt_a_pulse}; // R2
        ev_b        = '0;
        ev_b[EVB_DATA_CHANGE] = data_change; // R11
        ev_b[EVB_DOTTING]     = voice_dotting;
        ev_b[EVB_VOICE_FRAME] = voice_frame_sync;
        ev_b[EVB_SYNC_CHANGE] = ctrl_sync != st.sync_last;
        ev_b[EVB_IDLE_CHANGE] = idle_save != st.idle_last;
        ev_b[EVB_ERR_UPDATE]  = narrowband_error_update;
        ev_b[EVB_PORT_INPUT]  = port_input_three;
        ev_b[EVB_FREQ_CORR]   = freq_corr_done;
        // Masks gate only the line, never the flags
        pending = |(st.live_a & evt_a_mask) || |(st.live_b & evt_b_mask); // R20
        rd_evt_a = rd_req.start && (rd_req.addr == ADDR_EVT_A);
    end

    // Status word two, unused bits read zero
    always_comb
    begin
        status_two                   = RESET_BYTE;
        status_two[ST2_WORDS_DIFFER] = st.words_differ; // R1
        status_two[ST2_VOICE_MSG]    = voice_msg_rx;
        status_two[ST2_CTRL_SYNC]    = ctrl_sync;
        status_two[ST2_IDLE_SAVE]    = idle_save;
    end

    // Erasure population count for the decoder
    always_comb
    begin
        erase_count = '0;
        for (int k = 0; k < RX_BITS; k++)
        begin
            erase_count = erase_count + {5'h00, bit_erased[k]};
        end
    end

    // Next-state logic
    always_comb
    begin
        next_st = st;

        // Tone and level history
        if (tone_eval)
        begin
            next_st.tone_seen = 1'b1;
            next_st.tone_last = tone_mismatch;
        end
        next_st.sync_last = ctrl_sync;
        next_st.idle_last = idle_save;

        // Received word capture and comparison
        if (rx_word_in.valid)
        begin
            next_st.word_seen        = 1'b1;
            next_st.words_differ     = data_change;
            next_st.prev_word        = rx_word_in.data;
            next_st.rx_word          = rx_word_in.data;
            next_st.dec_status       = rx_word_in.status;
            next_st.erasure_over_two = erase_count > 6'(ERASURE_MAX);
        end

        // Live flags accumulate; a set in the read cycle is never lost
        next_st.live_a = st.live_a | ev_a; // R4
        next_st.live_b = st.live_b | ev_b; // R4

        if (rd_evt_a)
        begin
            // Snapshot both, restart live capture from this cycle's events
            next_st.buf_a  = st.live_a; // R6
            next_st.buf_b  = st.live_b | ((st.seq == SEQ_HOLD) ? st.buf_b : '0); // R10
            next_st.live_a = ev_a; // R5
            next_st.live_b = ev_b; // R5
            next_st.seq    = SEQ_HOLD; // R6
        end
        else if (rd_req.done && (rd_req.addr == ADDR_EVT_B) && (st.seq == SEQ_HOLD))
        begin
            next_st.seq   = SEQ_IDLE; // R9
            next_st.buf_b = '0;
        end

        // Interrupt line: low through a read sequence, high at its end
        if (rd_evt_a)
        begin
            next_st.irq_n = 1'b0; // R6
        end
        else if (st.seq == SEQ_HOLD)
        begin
            next_st.irq_n = (next_st.seq == SEQ_IDLE); // R7 R9
        end
        else
        begin
            next_st.irq_n = !pending; // R21
        end

        // Read data, latched when the address arrives
        if (rd_req.start)
        begin
            case (rd_req.addr)
                ADDR_STATUS_TWO: next_st.rd_data = status_two;
                ADDR_EVT_A:      next_st.rd_data = {1'b0, st.live_a};
                ADDR_EVT_B:      next_st.rd_data = st.buf_b; // R8
                ADDR_RX_BYTE0:   next_st.rd_data = st.rx_word[RX_B0_LSB +: BYTE_W]; // R15
                ADDR_RX_BYTE1:   next_st.rd_data = st.rx_word[RX_B1_LSB +: BYTE_W]; // R15
                ADDR_RX_BYTE2:   next_st.rd_data = st.rx_word[RX_B2_LSB +: BYTE_W]; // R15
                ADDR_RX_BYTE3:   next_st.rd_data = {st.rx_word[NIB_W-1:0], st.dec_status}; // R16 R17 R18
                default:         next_st.rd_data = RESET_BYTE;
            endcase
        end

        // Lock pin: voice message in voice mode, channel sync otherwise
        next_st.channel_lock = channel_type_select ? voice_msg_rx : ctrl_sync; // R14
    end

    // State register; clock enable freezes everything
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st       <= '0;
            st.irq_n <= 1'b1;
        end
        else if (clk_en)
        begin
            st <= next_st;
        end
    end

    assign rd_data             = st.rd_data;
    assign interrupt_request_n = st.irq_n;
    assign channel_lock        = st.channel_lock;
    assign erasure_over_two    = st.erasure_over_two;

    // Addressing register A pulls the line low on the next edge
    a_irq_drop_read: assert property ( // R6
        @(posedge clk) disable iff (!rst_b)
        clk_en && rd_evt_a |=> !interrupt_request_n)
        else $error("irq did not drop when event register A addressed");

    // Snapshot equals live contents at the addressing edge
    a_snapshot_taken: assert property ( // R6
        @(posedge clk) disable iff (!rst_b)
        clk_en && rd_evt_a |=> st.buf_a == $past(st.live_a))
        else $error("event snapshot does not match live flags");

    // Live register restarts with only the events of that cycle
    a_live_cleared: assert property ( // R5
        @(posedge clk) disable iff (!rst_b)
        clk_en && rd_evt_a |=> st.live_a == $past(ev_a))
        else $error("live event register A not cleared on read");

    // Register B read returns the snapshot, not live flags
    a_b_from_buffer: assert property ( // R8
        @(posedge clk) disable iff (!rst_b)
        clk_en && rd_req.start && rd_req.addr == ADDR_EVT_B && !rd_evt_a
        |=> rd_data == $past(st.buf_b))
        else $error("register B read did not return buffered value");

    // Line stays low while the sequence is open
    a_hold_keeps_low: assert property ( // R7
        @(posedge clk) disable iff (!rst_b)
        clk_en && st.seq == SEQ_HOLD && !(rd_req.done && rd_req.addr == ADDR_EVT_B)
        |=> !interrupt_request_n)
        else $error("irq released before register B read finished");

    // Finishing the B read releases the line
    a_release_on_b: assert property ( // R9
        @(posedge clk) disable iff (!rst_b)
        clk_en && st.seq == SEQ_HOLD && rd_req.done && rd_req.addr == ADDR_EVT_B && !rd_evt_a
        |=> interrupt_request_n && st.seq == SEQ_IDLE)
        else $error("irq not released after register B read");

    // Events land in live flags whatever the mask
    a_event_caught: assert property ( // R4
        @(posedge clk) disable iff (!rst_b)
        clk_en && evt_a_pulse[0] |=> st.live_a[0])
        else $error("event A0 not captured");

    // Identical repeated word raises no change event
    a_no_repeat_event: assert property ( // R12
        @(posedge clk) disable iff (!rst_b)
        clk_en && rx_word_in.valid && st.word_seen && rx_word_in.data == st.prev_word
        |-> !ev_b[EVB_DATA_CHANGE])
        else $error("repeat word raised data change event");

    // Masked pending flag drives the line low outside a sequence
    a_idle_irq: assert property ( // R21
        @(posedge clk) disable iff (!rst_b)
        clk_en && st.seq == SEQ_IDLE && pending && !rd_req.start
        |=> !interrupt_request_n)
        else $error("pending masked event did not assert irq");

    // First tone evaluation always flags a change
    a_first_tone: assert property ( // R3
        @(posedge clk) disable iff (!rst_b)
        clk_en && tone_eval && !st.tone_seen && !rd_evt_a
        |=> st.live_a[EVA_TONE_CHANGE])
        else $error("first tone evaluation not flagged");

    // Lock pin tracks the selected source one cycle later
    a_lock_pin: assert property ( // R14
        @(posedge clk) disable iff (!rst_b)
        clk_en |=> channel_lock ==
            ($past(channel_type_select) ? $past(voice_msg_rx) : $past(ctrl_sync)))
        else $error("channel lock pin wrong");

    // Byte three layout: data bits high, status low
    a_byte3_layout: assert property ( // R16
        @(posedge clk) disable iff (!rst_b)
        clk_en && rx_word_in.valid ##1 clk_en && rd_req.start && rd_req.addr == ADDR_RX_BYTE3
        ##1 !rx_word_in.valid
        |-> rd_data == {$past(rx_word_in.data[3:0], 2), $past(rx_word_in.status, 2)})
        else $error("received byte three layout wrong");

    // Live A flags only drop at the addressing of A
    a_flags_a_kept: assert property ( // R4
        @(posedge clk) disable iff (!rst_b)
        clk_en && !rd_evt_a
        |=> (st.live_a & $past(st.live_a)) == $past(st.live_a))
        else $error("live event flag A lost without a read");

    // Live B flags only drop at the addressing of A
    a_flags_b_kept: assert property ( // R4
        @(posedge clk) disable iff (!rst_b)
        clk_en && !rd_evt_a
        |=> (st.live_b & $past(st.live_b)) == $past(st.live_b))
        else $error("live event flag B lost without a read");

    // First addressing of A copies live B into the buffer
    a_b_snapshot: assert property ( // R6
        @(posedge clk) disable iff (!rst_b)
        clk_en && rd_evt_a && st.seq == SEQ_IDLE
        |=> st.buf_b == $past(st.live_b))
        else $error("register B snapshot wrong");

    // A read again without B keeps the older B events queued
    a_b_queued: assert property ( // R10
        @(posedge clk) disable iff (!rst_b)
        clk_en && rd_evt_a && st.seq == SEQ_HOLD
        |=> st.buf_b == ($past(st.live_b) | $past(st.buf_b)))
        else $error("queued register B events lost");

    // A word that differs raises the change flag
    a_change_raised: assert property ( // R12
        @(posedge clk) disable iff (!rst_b)
        clk_en && rx_word_in.valid && st.word_seen && rx_word_in.data != st.prev_word
        |=> st.live_b[EVB_DATA_CHANGE])
        else $error("changed word raised no data change event");

    // Status word two shows the live levels at the read
    a_status_two: assert property ( // R1
        @(posedge clk) disable iff (!rst_b)
        clk_en && rd_req.start && rd_req.addr == ADDR_STATUS_TWO
        |=> rd_data == {3'h0, $past(idle_save), $past(ctrl_sync), $past(voice_msg_rx), 1'h0,
            $past(st.words_differ)})
        else $error("status word two layout wrong");

    // Register A is seven bits, the top bit reads zero
    a_a_top_zero: assert property ( // R2
        @(posedge clk) disable iff (!rst_b)
        clk_en && rd_evt_a
        |=> !rd_data[BYTE_W-1])
        else $error("event register A top bit set");

    // Erasure flag moves only with a new word
    a_erasure_hold: assert property ( // R19
        @(posedge clk) disable iff (!rst_b)
        clk_en && !rx_word_in.valid
        |=> $stable(erasure_over_two))
        else $error("erasure flag changed without a word");

    // Received bits captured as delivered
    a_word_capture: assert property ( // R15
        @(posedge clk) disable iff (!rst_b)
        clk_en && rx_word_in.valid
        |=> st.rx_word == $past(rx_word_in.data))
        else $error("received word not captured");

    // Decode status passed through unchanged
    a_status_pass: assert property ( // R17
        @(posedge clk) disable iff (!rst_b)
        clk_en && rx_word_in.valid
        |=> st.dec_status == $past(rx_word_in.status))
        else $error("decode status not captured");

    // Nothing pending under the masks keeps the line high
    a_irq_high_idle: assert property ( // R20
        @(posedge clk) disable iff (!rst_b)
        clk_en && st.seq == SEQ_IDLE && !pending && !rd_req.start
        |=> interrupt_request_n)
        else $error("irq asserted with no masked event pending");

endmodule : status_event_rx_readout

`default_nettype wire

/* verilog/evt_status_pkg.sv */
// Purpose: Constants, types and field layout for the status, event and rx readout bank
// Assumes: One clock domain; read framing logic sits outside and shares the clock
// Notes:   Rules carried by this block are listed below
// What this block does
// R1 - Status word two reports four live conditions
// R2 - Event register A holds seven event flags
// R3 - Tone changed flag set after first evaluation
// R4 - Flags set regardless of interrupt mask bits
// R5 - Both event registers clear when read
// R6 - Addressing A: irq low, buffer, clear live
// R7 - New events caught live; irq stays low
// R8 - Reading B returns buffered snapshot
// R9 - Completing B read drives irq high
// R10 - Read A then B; else events queue
// R11 - Event register B holds eight event flags
// R12 - Data change only on bitwise word difference
// R13 - Idle processing: mask rx-avail, unmask change
// R14 - Lock pin follows message or channel sync
// R15 - Bytes 0..2 hold rx bits 27..4
// R16 - Byte 3: bits 3..0 high, status low
// R17 - Decode status codes for normal decodes
// R18 - Decode status codes for heavy erasure cases
// R19 - Erasure: equal ones and zeros counted
// R20 - Interrupt only when mask bit set
// R21 - Irq asserted for pending masked events
package evt_status_pkg;

    // Read addresses
    localparam logic [6:0] ADDR_STATUS_TWO = 7'h01;
    localparam logic [6:0] ADDR_EVT_A      = 7'h05;
    localparam logic [6:0] ADDR_EVT_B      = 7'h06;
    localparam logic [6:0] ADDR_RX_BYTE0   = 7'h10;
    localparam logic [6:0] ADDR_RX_BYTE1   = 7'h11;
    localparam logic [6:0] ADDR_RX_BYTE2   = 7'h12;
    localparam logic [6:0] ADDR_RX_BYTE3   = 7'h13;

    // Status word two bit positions
    localparam int ST2_WORDS_DIFFER = 0;
    localparam int ST2_VOICE_MSG    = 2;
    localparam int ST2_CTRL_SYNC    = 3;
    localparam int ST2_IDLE_SAVE    = 4;

    // Event register B bit positions, and the tone change bit of register A
    localparam int EVB_DATA_CHANGE  = 0;
    localparam int EVB_DOTTING      = 1;
    localparam int EVB_VOICE_FRAME  = 2;
    localparam int EVB_SYNC_CHANGE  = 3;
    localparam int EVB_IDLE_CHANGE  = 4;
    localparam int EVB_ERR_UPDATE   = 5;
    localparam int EVB_PORT_INPUT   = 6;
    localparam int EVB_FREQ_CORR    = 7;
    localparam int EVA_TONE_CHANGE  = 6;

    localparam int RX_BITS      = 28;
    localparam int VOTE_W       = 4;
    localparam int ERASURE_MAX  = 2;
    localparam logic [7:0] RESET_BYTE = 8'h00;

    // Received word byte fields, low bit of each byte
    localparam int RX_B0_LSB   = 20;
    localparam int RX_B1_LSB   = 12;
    localparam int RX_B2_LSB   = 4;
    localparam int BYTE_W      = 8;
    localparam int NIB_W       = 4;

    // Decode status encodings
    typedef enum logic [3:0] {
        DEC_NO_ERR        = 4'h0,
        DEC_ONE_PAR       = 4'h1,
        DEC_TWO_PAR       = 4'h2,
        DEC_ONE_DATA      = 4'h4,
        DEC_ONE_DATA_PAR  = 4'h5,
        DEC_TWO_DATA      = 4'h8,
        DEC_ERAS_DATA     = 4'hC,
        DEC_ERAS_PAR      = 4'hD,
        DEC_ERAS_TWO_PAR  = 4'hE,
        DEC_UNCORRECTED   = 4'hF
    } decode_status_t;

    typedef enum logic [0:0] {
        SEQ_IDLE = 1'b0,
        SEQ_HOLD = 1'b1
    } seq_t;

    // Read request from the serial framing logic
    typedef struct packed {
        logic       start;
        logic       done;
        logic [6:0] addr;
    } rd_req_t;

    // Decoded word from the receive decoder
    typedef struct packed {
        logic                valid;
        logic [RX_BITS-1:0]  data;
        logic [3:0]          status;
    } rx_word_t;

    // All block state
    typedef struct packed {
        seq_t               seq;
        logic               irq_n;
        logic [7:0]         rd_data;
        logic [6:0]         live_a;
        logic [7:0]         live_b;
        logic [6:0]         buf_a;
        logic [7:0]         buf_b;
        logic [RX_BITS-1:0] prev_word;
        logic               word_seen;
        logic               words_differ;
        logic [RX_BITS-1:0] rx_word;
        logic [3:0]         dec_status;
        logic               tone_seen;
        logic               tone_last;
        logic               sync_last;
        logic               idle_last;
        logic               channel_lock;
        logic               erasure_over_two;
    } state_t;

endpackage : evt_status_pkg

/* testbench/mcu_reader.sv */
// Purpose: Microcontroller side of the status and event read port
// Assumes: Requests change on the falling clock edge
// Notes:   Address goes to its inverse once a read is closed
`timescale 1ns/1ps
`default_nettype none

module mcu_reader
    import evt_status_pkg::*;
(
    input  wire logic       clk,
    input  wire logic [7:0] rd_data,
    output var  rd_req_t    rd_req
);
    initial rd_req = '0;

    // Address, take data a cycle later, close with done
    task automatic read(input logic [6:0] addr, output logic [7:0] data);
        @(negedge clk);
        rd_req.addr  = addr;
        rd_req.start = 1'b1;
        @(negedge clk);
        rd_req.start = 1'b0;
        data         = rd_data;
        rd_req.done  = 1'b1;
        @(negedge clk);
        rd_req.done  = 1'b0;
        rd_req.addr  = ~addr; // Stale address must not look held
    endtask : read

    // Events always read as a pair, A first
    task automatic read_events(output logic [7:0] a, output logic [7:0] b);
        read(ADDR_EVT_A, a);
        read(ADDR_EVT_B, b);
    endtask : read_events
endmodule : mcu_reader
`default_nettype wire

/* testbench/testbench.sv */
// Purpose: Self-checking bench for the status, event and rx readout bank
// Assumes: Every stimulus changes on the falling clock edge
// Notes:   Decode codes run from a table; event protocol is hand-written
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import evt_status_pkg::*;
    typedef struct packed {logic [27:0] d; logic [3:0] st; logic [4:0] n_er;} row_t;
    logic                      clk, rst_b, irq_n, eras, lock, tone_eval, tone_mm, ce;
    logic                      voice, sync, idle, sel, dot, vfs, nb, pio, afc;
    logic [7:0]                rd_data, b_mask, got, got_b;
    logic [6:0]                a_mask;
    logic [5:0]                a_pulse;
    logic [RX_BITS*VOTE_W-1:0] v1, v0;
    rx_word_t                  rx;
    rd_req_t                   rq;
    int                        n_fail = 0;
    int                        checked = 0;
    // One row per decode status code, erasure count at the boundary too
    row_t rows [10] = '{'{28'hABCDEF1, 4'h0, 5'h00}, '{28'h1234567, 4'h1, 5'h01},
        '{28'h8000001, 4'h2, 5'h02}, '{28'h7FFFFFE, 4'h4, 5'h00},
        '{28'h0F0F0F0, 4'h5, 5'h00}, '{28'hF0F0F0F, 4'h8, 5'h02},
        '{28'h5555555, 4'hC, 5'h03}, '{28'hAAAAAAA, 4'hD, 5'h03},
        '{28'h0000001, 4'hE, 5'h04}, '{28'hFFFFFFF, 4'hF, 5'h1C}};

    // Free-running 100 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    status_event_rx_readout DUT (.clk(clk), .rst_b(rst_b), .clk_en(ce), .rd_req(rq),
        .rd_data(rd_data), .interrupt_request_n(irq_n), .evt_a_mask(a_mask),
        .evt_b_mask(b_mask), .evt_a_pulse(a_pulse), .tone_eval(tone_eval),
        .tone_mismatch(tone_mm), .rx_word_in(rx), .vote_ones(v1), .vote_zeros(v0),
        .erasure_over_two(eras), .voice_msg_rx(voice), .ctrl_sync(sync),
        .idle_save(idle), .channel_type_select(sel), .voice_dotting(dot),
        .voice_frame_sync(vfs), .narrowband_error_update(nb), .port_input_three(pio),
        .freq_corr_done(afc), .channel_lock(lock));

    mcu_reader mcu (.clk(clk), .rd_data(rd_data), .rd_req(rq));

    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] val);
        checked++;
        if (val !== exp)
        begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, val);
        end
    endtask : chk

    task automatic rd(input logic [6:0] a, input logic [7:0] exp, input string nm);
        mcu.read(a, got);
        chk(nm, exp, got);
    endtask : rd

    // One-cycle event pulses
    task automatic ev(input logic [5:0] a, input logic [4:0] b, input logic t);
        @(negedge clk);
        {a_pulse, dot, vfs, nb, pio, afc, tone_eval} = {a, b, t};
        @(negedge clk);
        {a_pulse, dot, vfs, nb, pio, afc, tone_eval} = '0;
    endtask : ev

    task automatic word(input logic [27:0] d, input logic [3:0] s);
        @(negedge clk);
        rx = '{1'b1, d, s};
        @(negedge clk);
        rx.valid = 1'b0;
    endtask : word

    task automatic test_done;
        $display("checks %0d failures %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : test_done

    // Watchdog against a hung sequence
    initial
    begin
        repeat (20000) @(posedge clk);
        n_fail++;
        $display("[FAIL] watchdog expected end seen hang");
        test_done();
    end

    // Main sequence
    initial
    begin
        {rst_b, tone_eval, tone_mm, voice, sync, idle, sel} = '0;
        {dot, vfs, nb, pio, afc, b_mask, a_mask, a_pulse, v1, v0} = '0;
        rx = '0;
        ce = 1'b1;
        repeat (20) @(negedge clk);
        chk("rst irq", 8'h01, {7'h00, irq_n});
        chk("rst data", 8'h00, rd_data);
        chk("rst lock", 8'h00, {7'h00, lock});
        chk("rst eras", 8'h00, {7'h00, eras});
        rst_b = 1'b1;
        rd(7'h02, 8'h00, "unmapped 02");
        rd(7'h7F, 8'h00, "unmapped 7F");
        // Table: every decode code, byte layout and erasure count
        foreach (rows[i])
        begin
            for (int k = 0; k < RX_BITS; k++)
            begin
                v1[k*4 +: 4] = 4'h2;
                v0[k*4 +: 4] = (k < rows[i].n_er) ? 4'h2 : 4'h1;
            end
            word(rows[i].d, rows[i].st);
            chk("erasure", {7'h00, rows[i].n_er > 5'h02}, {7'h00, eras});
            rd(ADDR_RX_BYTE0, rows[i].d[27:20], "byte0");
            rd(ADDR_RX_BYTE1, rows[i].d[19:12], "byte1");
            rd(ADDR_RX_BYTE2, rows[i].d[11:4], "byte2");
            rd(ADDR_RX_BYTE3, {rows[i].d[3:0], rows[i].st}, "byte3");
        end
        // Byte three read in the cycle right after capture
        fork
            word(28'h000000A, 4'h5);
            begin
                @(negedge clk);
                mcu.read(ADDR_RX_BYTE3, got);
            end
        join
        chk("byte3 next", 8'hA5, got);
        mcu.read_events(got, got_b);
        // Repeated identical word raises no second change event
        word(28'h0123456, 4'h0);
        mcu.read_events(got, got_b);
        chk("change new", 8'h01, got_b & 8'h01);
        rd(ADDR_STATUS_TWO, 8'h01, "st2 differ");
        word(28'h0123456, 4'h0);
        rd(ADDR_STATUS_TWO, 8'h00, "st2 same");
        mcu.read_events(got, got_b);
        chk("change same", 8'h00, got_b & 8'h01);
        // Events with masks clear: flags set, line quiet
        @(negedge clk);
        {voice, sync, idle} = 3'b111;
        ev(6'h3F, 5'h1F, 1'b1);
        repeat (2) @(negedge clk);
        chk("irq masked", 8'h01, {7'h00, irq_n});
        rd(ADDR_STATUS_TWO, 8'h1C, "st2 levels");
        a_mask = 7'h7F;
        repeat (2) @(negedge clk);
        chk("irq pending", 8'h00, {7'h00, irq_n});
        rd(ADDR_EVT_A, 8'h7F, "evt a");
        chk("irq in seq", 8'h00, {7'h00, irq_n});
        ev(6'h01, 5'h00, 1'b0);
        chk("irq held", 8'h00, {7'h00, irq_n});
        rd(ADDR_EVT_B, 8'hFE, "evt b buf");
        chk("irq release", 8'h01, {7'h00, irq_n});
        @(negedge clk);
        chk("irq requeue", 8'h00, {7'h00, irq_n});
        rd(ADDR_EVT_A, 8'h01, "evt a new");
        rd(ADDR_EVT_B, 8'h00, "evt b clr");
        // Idle processing masks: rx-avail off, data change on
        a_mask = 7'h00;
        b_mask = 8'h01;
        ev(6'h01, 5'h00, 1'b0);
        repeat (2) @(negedge clk);
        chk("idle quiet", 8'h01, {7'h00, irq_n});
        word(28'h7654321, 4'h0);
        repeat (2) @(negedge clk);
        chk("idle wake", 8'h00, {7'h00, irq_n});
        mcu.read_events(got, got_b);
        // A read alone queues B events until B is read
        ev(6'h00, 5'h10, 1'b0);
        rd(ADDR_EVT_A, 8'h00, "evt a only");
        ev(6'h00, 5'h08, 1'b0);
        rd(ADDR_EVT_A, 8'h00, "evt a again");
        rd(ADDR_EVT_B, 8'h06, "evt b queued");
        // Lock pin follows channel mode
        @(negedge clk);
        {sel, voice, sync} = 3'b001;
        repeat (2) @(negedge clk);
        chk("lock ctrl", 8'h01, {7'h00, lock});
        {sel, voice, sync} = 3'b101;
        repeat (2) @(negedge clk);
        chk("lock voice0", 8'h00, {7'h00, lock});
        voice = 1'b1;
        repeat (2) @(negedge clk);
        chk("lock voice1", 8'h01, {7'h00, lock});
        // Clock enable low freezes the lock pin
        ce    = 1'b0;
        voice = 1'b0;
        repeat (2) @(negedge clk);
        chk("lock frozen", 8'h01, {7'h00, lock});
        // Mid-run reset acts at once, even with the enable low
        voice = 1'b1;
        rst_b = 1'b0;
        #1;
        chk("mid rst lock", 8'h00, {7'h00, lock});
        chk("mid rst irq", 8'h01, {7'h00, irq_n});
        chk("mid rst data", 8'h00, rd_data);
        @(negedge clk);
        ce = 1'b1;
        repeat (2) @(negedge clk);
        rst_b = 1'b1;
        repeat (2) @(negedge clk);
        chk("lock after rst", 8'h01, {7'h00, lock});
        mcu.read_events(got, got_b);
        chk("rst evt a", 8'h00, got);
        chk("rst evt b", 8'h18, got_b);
        test_done();
    end
endmodule : testbench
`default_nettype wire
